//--- logic/cccs_pkg.sv
`default_nettype none
package cccs_pkg;
    // Characters seen in program messages and written into responses.
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_QM = 8'h3F;
    localparam logic [7:0] CH_SEMI = 8'h3B;
    localparam logic [7:0] CH_NL = 8'h0A;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_ONE = 8'h31;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_Z = 8'h5A;
    localparam logic [7:0] CASE_MASK = 8'hDF;
    // Three-letter common command headers, upper case.
    localparam logic [23:0] CMD_CLS = 24'h43_4C53;
    localparam logic [23:0] CMD_ESE = 24'h45_5345;
    localparam logic [23:0] CMD_ESR = 24'h45_5352;
    localparam logic [23:0] CMD_IDN = 24'h49_444E;
    localparam logic [23:0] CMD_IST = 24'h49_5354;
    localparam logic [23:0] CMD_OPC = 24'h4F_5043;
    localparam logic [23:0] CMD_OPT = 24'h4F_5054;
    localparam logic [23:0] CMD_RST = 24'h52_5354;
    localparam logic [23:0] CMD_SRE = 24'h53_5245;
    localparam logic [23:0] CMD_STB = 24'h53_5442;
    localparam logic [23:0] CMD_TRG = 24'h54_5247;
    localparam logic [23:0] CMD_TST = 24'h54_5354;
    localparam logic [23:0] CMD_WAI = 24'h57_4149;
    // Bit positions in the event register, status byte and summary register.
    localparam int ESR_OPC = 0;
    localparam int ESR_CME = 5;
    localparam int STB_QUES = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_MSS = 6;
    localparam int STB_OPER = 7;
    localparam int SUMM_QUES = 0;
    localparam int SUMM_OPER = 1;
    localparam int SUMM_IST = 2;
    localparam logic [7:0] SRE_MASK = 8'hBF;
    localparam logic [7:0] ESE_RST = 8'h00;
    localparam logic [7:0] SRE_RST = 8'h00;
    localparam logic [7:0] ESR_RST = 8'h00;
    // Register port offsets.
    localparam logic [1:0] REG_STB = 2'h0;
    localparam logic [1:0] REG_ESR = 2'h1;
    localparam logic [1:0] REG_EVT = 2'h2;
    localparam logic [1:0] REG_SUMM = 2'h3;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_HDR = 3'b001, S_PARM = 3'b010, S_SKIP = 3'b011,
        S_EXEC = 3'b100, S_WAIT = 3'b101, S_TEST = 3'b110, S_RESP = 3'b111
    } cccs_state_t;
    typedef struct packed {
        logic [23:0] hdr;
        logic [1:0] nlet;
        logic query;
        logic bad;
        logic [7:0] value;
    } cccs_cmd_t;
    typedef struct packed {
        logic preset;
        logic trigger;
        logic test_start;
        logic evt_clear;
        logic abort;
    } cccs_act_t;
endpackage
`default_nettype wire

//--- logic/cccs_core.sv
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RQ1] Commands do not stall each other unless a sync command asks for it.
// [RQ2] Operation-complete command sets event bit 0 once prior work is finished.
// [RQ3] Operation-complete query stalls parsing until idle, then answers 1.
// [RQ4] Wait command stalls later commands until prior work has settled.
// [RQ5] Controller enables event bit 0 and service bit 5 to get notified.
// [RQ6] Controller syncs after sweep start, single sweep and marker queries.
// [RQ7] A new command during a long measurement may abort that measurement.
// [RQ8] Common header is asterisk, exactly three letters, optional question mark.
// [RQ9] Clear-status zeroes status byte, event register, questionable and operation events.
// [RQ10] Clear-status leaves every enable and transition part unchanged.
// [RQ11] Clear-status discards pending response characters.
// [RQ12] Event enable command loads 0 to 255; its query returns it.
// [RQ13] Event read query returns the event register then clears it.
// [RQ14] Individual status query returns the parallel poll flag as 0 or 1.
// [RQ15] Service enable loads 0 to 255 with bit 6 forced to zero.
// [RQ16] Status byte query returns the status byte, query only.
// [RQ17] Trigger command pulses a manual trigger to waiting actions.
// [RQ18] Self-test query runs the test and returns 0 or an error code.
// [RQ19] A running self-test is not aborted; local mode waits for it.
// [RQ20] Reset command presets all settings, like system preset, setting only.
// [RQ21] Messages end in newline; commands inside are split by semicolons.
// [RQ22] Boolean answers are the characters 0 and 1.
// [RQ23] Status bit 5 is set while event register AND its enable is nonzero.
// [RQ24] Service request is asserted while status byte AND service enable is nonzero.
module cccs_core #(
    parameter logic [7:0] ID_CODE = 8'h2A, // Arbitrary identification value.
    parameter int CHAR_W = 8
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_char_i,
    output logic rx_ready_o,
    output logic tx_valid_o,
    output logic [7:0] tx_char_o,
    input wire logic tx_ready_i,
    input wire logic ops_busy_i,
    input wire logic test_done_i,
    input wire logic [7:0] test_code_i,
    input wire logic local_req_i,
    output logic go_local_o,
    output cccs_pkg::cccs_act_t act_o,
    output logic [7:0] stb_o,
    output logic srq_o,
    input wire logic [1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o
);
    import cccs_pkg::*;

    // The character path is byte wide only.
    generate
        if (CHAR_W != 8) begin : g_chk
            $error("CHAR_W must be 8.");
        end
    endgenerate

    cccs_state_t state;
    cccs_state_t next_state;
    cccs_cmd_t cmd;
    logic [7:0] ese;
    logic [7:0] sre;
    logic [7:0] esr;
    logic [2:0] summ;
    logic opc_pend;
    logic [1:0] resp_left;
    logic [2:0][7:0] resp_rest;
    logic take;
    logic is_term;
    logic is_space;
    logic is_letter;
    logic is_digit;
    logic [11:0] next_acc;
    logic cmd_ok;
    logic [7:0] imm_val;
    logic load_resp;
    logic [7:0] load_val;
    logic cme;
    logic ex;
    logic opc_done;
    logic [7:0] next_stb;
    logic next_mss;

    // Character classes of the incoming stream.
    assign take = rx_valid_i && rx_ready_o;
    assign is_term = (rx_char_i == CH_NL) || (rx_char_i == CH_SEMI); // RQ21
    assign is_space = (rx_char_i <= CH_SPACE) && !is_term;
    assign is_letter = ((rx_char_i & CASE_MASK) >= CH_A) && ((rx_char_i & CASE_MASK) <= CH_Z);
    assign is_digit = (rx_char_i >= CH_ZERO) && (rx_char_i <= CH_NINE);
    assign next_acc = {4'h0, cmd.value} * 12'd10 + {4'h0, rx_char_i - CH_ZERO};
    assign ex = (state == S_EXEC) && cmd_ok;
    assign opc_done = opc_pend && !ops_busy_i;

    // Legal query forms and the value of an immediate answer.
    always_comb begin
        cmd_ok = 1'b0;
        imm_val = 8'h00;
        case (cmd.hdr)
            CMD_CLS, CMD_RST, CMD_TRG, CMD_WAI: cmd_ok = !cmd.query; // RQ20
            CMD_ESE: begin
                cmd_ok = 1'b1;
                imm_val = ese; // RQ12
            end
            CMD_SRE: begin
                cmd_ok = 1'b1;
                imm_val = sre;
            end
            CMD_OPC: cmd_ok = 1'b1;
            CMD_ESR: begin
                cmd_ok = cmd.query;
                imm_val = esr; // RQ13
            end
            CMD_IDN: begin
                cmd_ok = cmd.query;
                imm_val = ID_CODE;
            end
            CMD_IST: begin
                cmd_ok = cmd.query;
                imm_val = {7'h00, summ[SUMM_IST]}; // RQ14 RQ22
            end
            CMD_STB: begin
                cmd_ok = cmd.query;
                imm_val = stb_o; // RQ16
            end
            CMD_OPT, CMD_TST: cmd_ok = cmd.query;
            default: cmd_ok = 1'b0;
        endcase
        if (cmd.bad || cmd.nlet != 2'd3) begin
            cmd_ok = 1'b0; // RQ8
        end
    end

    // Next state of the command sequencer.
    always_comb begin
        next_state = state;
        load_resp = 1'b0;
        load_val = 8'h00;
        cme = 1'b0;
        unique case (state)
            S_IDLE: begin
                if (take && rx_char_i == CH_STAR) begin
                    next_state = S_HDR; // RQ8
                end else if (take && !is_term && !is_space) begin
                    next_state = S_SKIP;
                end
            end
            S_HDR, S_PARM: begin
                if (take && is_term) begin
                    next_state = S_EXEC; // RQ21
                end else if (take && state == S_HDR && is_space) begin
                    next_state = S_PARM;
                end
            end
            S_SKIP: begin
                if (take && is_term) begin
                    next_state = S_IDLE;
                end
            end
            S_EXEC: begin
                if (!cmd_ok) begin
                    cme = 1'b1;
                    next_state = S_IDLE;
                end else if (cmd.hdr == CMD_WAI || (cmd.hdr == CMD_OPC && cmd.query)) begin
                    next_state = S_WAIT; // RQ3 RQ4
                end else if (cmd.hdr == CMD_TST) begin
                    next_state = S_TEST; // RQ18
                end else if (cmd.query) begin
                    next_state = S_RESP;
                    load_resp = 1'b1;
                    load_val = imm_val;
                end else begin
                    next_state = S_IDLE; // RQ1
                end
            end
            S_WAIT: begin
                if (!ops_busy_i && cmd.query) begin
                    next_state = S_RESP;
                    load_resp = 1'b1;
                    load_val = 8'h01; // RQ3
                end else if (!ops_busy_i) begin
                    next_state = S_IDLE; // RQ4
                end
            end
            S_TEST: begin
                if (test_done_i) begin
                    next_state = S_RESP;
                    load_resp = 1'b1;
                    load_val = test_code_i; // RQ18
                end
            end
            S_RESP: begin
                if (tx_valid_o && tx_ready_i && resp_left == 2'd0) begin
                    next_state = S_IDLE;
                end
            end
        endcase
    end

    // Sequencer state; input is accepted only in the parsing states.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state <= S_IDLE;
            rx_ready_o <= 1'b0;
        end else begin
            state <= next_state;
            rx_ready_o <= (next_state == S_IDLE) || (next_state == S_HDR) ||
                (next_state == S_PARM) || (next_state == S_SKIP); // RQ3 RQ4
        end
    end

    // Header letters, query mark and decimal parameter of the command.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cmd <= '0;
        end else if (state == S_IDLE && take) begin
            cmd <= '0;
        end else if (take && (state == S_HDR || state == S_PARM) && !is_term) begin
            if (state == S_HDR && is_letter && !cmd.query) begin
                if (cmd.nlet == 2'd3) begin
                    cmd.bad <= 1'b1; // RQ8
                end else begin
                    cmd.hdr <= {cmd.hdr[15:0], rx_char_i & CASE_MASK};
                    cmd.nlet <= cmd.nlet + 2'd1;
                end
            end else if (state == S_HDR && rx_char_i == CH_QM && cmd.nlet == 2'd3 && !cmd.query) begin
                cmd.query <= 1'b1; // RQ8
            end else if (state == S_PARM && is_digit) begin
                cmd.value <= (next_acc > 12'h0FF) ? 8'hFF : next_acc[7:0];
            end else if (!is_space) begin
                cmd.bad <= 1'b1;
            end
        end
    end

    // Enable registers; clear-status never touches them.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ese <= ESE_RST;
            sre <= SRE_RST;
        end else if (ex && !cmd.query && cmd.hdr == CMD_ESE) begin
            ese <= cmd.value; // RQ12 RQ10
        end else if (ex && !cmd.query && cmd.hdr == CMD_SRE) begin
            sre <= cmd.value & SRE_MASK; // RQ15 RQ10
        end
    end

    // Pending operation-complete waits for the earlier work to finish.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            opc_pend <= 1'b0;
        end else if (ex && !cmd.query && cmd.hdr == CMD_OPC) begin
            opc_pend <= 1'b1; // RQ2
        end else if (!ops_busy_i) begin
            opc_pend <= 1'b0;
        end
    end

    // Event register: a set in the clearing cycle survives the clear.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            esr <= ESR_RST;
        end else begin
            esr <= ((ex && (cmd.hdr == CMD_CLS || cmd.hdr == CMD_ESR)) ? 8'h00 : esr) // RQ9 RQ13
                | (8'(opc_done) << ESR_OPC) // RQ2
                | (8'(cme) << ESR_CME)
                | ((reg_wr_i && reg_addr_i == REG_EVT) ? reg_wdata_i : 8'h00);
        end
    end

    // Questionable, operation and parallel poll summaries fed by software.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            summ <= 3'b000;
        end else if (reg_wr_i && reg_addr_i == REG_SUMM) begin
            summ <= reg_wdata_i[2:0];
        end else if (ex && cmd.hdr == CMD_CLS) begin
            summ[SUMM_QUES] <= 1'b0; // RQ9
            summ[SUMM_OPER] <= 1'b0; // RQ9
        end
    end

    // Status byte summary and service request.
    always_comb begin
        next_stb = 8'h00;
        next_stb[STB_QUES] = summ[SUMM_QUES];
        next_stb[STB_OPER] = summ[SUMM_OPER];
        next_stb[STB_MAV] = tx_valid_o;
        next_stb[STB_ESB] = |(esr & ese); // RQ23
        next_mss = |(next_stb & sre); // RQ24
        next_stb[STB_MSS] = next_mss;
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            stb_o <= 8'h00;
            srq_o <= 1'b0;
        end else begin
            stb_o <= next_stb; // RQ23
            srq_o <= next_mss; // RQ24
        end
    end

    // Response output: decimal digits without leading zeros, then newline.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            tx_valid_o <= 1'b0;
            tx_char_o <= 8'h00;
            resp_left <= 2'd0;
            resp_rest <= '0;
        end else if (ex && cmd.hdr == CMD_CLS) begin
            tx_valid_o <= 1'b0; // RQ11
            resp_left <= 2'd0;
        end else if (load_resp) begin
            tx_valid_o <= 1'b1;
            if (load_val >= 8'd100) begin
                tx_char_o <= CH_ZERO + load_val / 8'd100;
                resp_rest <= {CH_NL, CH_ZERO + load_val % 8'd10, CH_ZERO + (load_val / 8'd10) % 8'd10};
                resp_left <= 2'd3;
            end else if (load_val >= 8'd10) begin
                tx_char_o <= CH_ZERO + load_val / 8'd10;
                resp_rest <= {8'h00, CH_NL, CH_ZERO + load_val % 8'd10};
                resp_left <= 2'd2;
            end else begin
                tx_char_o <= CH_ZERO + load_val; // RQ22
                resp_rest <= {8'h00, 8'h00, CH_NL};
                resp_left <= 2'd1;
            end
        end else if (tx_valid_o && tx_ready_i) begin
            if (resp_left == 2'd0) begin
                tx_valid_o <= 1'b0;
            end else begin
                tx_char_o <= resp_rest[0];
                resp_rest <= {8'h00, resp_rest[2:1]};
                resp_left <= resp_left - 2'd1;
            end
        end
    end

    // Action pulses toward the measurement logic.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            act_o <= '0;
        end else begin
            act_o.preset <= ex && cmd.hdr == CMD_RST; // RQ20
            act_o.trigger <= ex && cmd.hdr == CMD_TRG; // RQ17
            act_o.test_start <= ex && cmd.hdr == CMD_TST; // RQ18
            act_o.evt_clear <= ex && cmd.hdr == CMD_CLS; // RQ9
            act_o.abort <= ex && ops_busy_i && (cmd.hdr == CMD_RST || cmd.hdr == CMD_TRG); // RQ7
        end
    end

    // Return to local waits for a running self-test.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            go_local_o <= 1'b0;
        end else begin
            go_local_o <= local_req_i && state != S_TEST && next_state != S_TEST; // RQ19
        end
    end

    // Register port read data, one cycle after the strobe.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_STB: reg_rdata_o <= stb_o;
                REG_ESR: reg_rdata_o <= esr;
                REG_EVT: reg_rdata_o <= ese;
                REG_SUMM: reg_rdata_o <= {5'h00, summ};
            endcase
        end
    end

    // Checks on the sequencing and status logic.
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    sequence seq_wait_done;
        state == S_WAIT && cmd.query && !ops_busy_i;
    endsequence

    sequence seq_one_out;
        tx_valid_o && tx_char_o == CH_ONE && state == S_RESP;
    endsequence

    AST_OPCQ_ONE: assert property (seq_wait_done |=> seq_one_out) // RQ3
        else $error("Operation-complete query did not answer 1.");
    AST_WAIT_HOLD: assert property (state == S_WAIT |-> !rx_ready_o) // RQ4
        else $error("Input accepted while waiting for completion.");
    AST_OPC_BIT: assert property ($rose(esr[ESR_OPC]) |-> // RQ2
        ($past(opc_pend) && !$past(ops_busy_i)) || ($past(reg_wr_i) && $past(reg_addr_i) == REG_EVT))
        else $error("Operation-complete bit set while work was pending.");
    AST_CLS_MASK: assert property (ex && cmd.hdr == CMD_CLS |=> $stable(ese) && $stable(sre)) // RQ10
        else $error("Clear-status changed an enable register.");
    AST_CLS_ZERO: assert property (ex && cmd.hdr == CMD_CLS && !reg_wr_i && !opc_pend // RQ9
        |=> esr == 8'h00 && !tx_valid_o)
        else $error("Clear-status left events or response behind.");
    AST_SRE_B6: assert property (!sre[STB_MSS]) // RQ15
        else $error("Service enable bit 6 is set.");
    AST_ESB: assert property (stb_o[STB_ESB] == |($past(esr) & $past(ese))) // RQ23
        else $error("Event summary bit disagrees with enabled events.");
    AST_SRQ: assert property (srq_o == |(stb_o & $past(sre))) // RQ24
        else $error("Service request disagrees with enabled status.");
    AST_LOCAL: assert property (state == S_TEST |=> !go_local_o) // RQ19
        else $error("Local mode granted during self-test.");
    AST_HDR_CME: assert property (state == S_EXEC && cmd.nlet != 2'd3 |=> esr[ESR_CME]) // RQ8
        else $error("Malformed header not flagged.");
endmodule
`default_nettype wire

//--- verification/cccs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Remote controller model that sends command text and collects response characters.
module cccs_ctrl_model (
    input wire logic clk_i,
    input wire logic rx_ready_i,
    output logic rx_valid_o,
    output logic [7:0] rx_char_o,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_char_i,
    output logic tx_ready_o,
    input wire logic slow_i
);
    logic [7:0] rxq[$];
    logic stuck;
    int cyc;
    // Lines start idle so the block sees no stray character.
    initial begin
        rx_valid_o = 1'b0;
        rx_char_o = 8'h00;
        tx_ready_o = 1'b1;
        stuck = 1'b0;
        cyc = 0;
    end
    // Holds each character until taken, and after the last one inverts the line so no stale value lingers.
    task automatic send(input string s);
        int n;
        for (int i = 0; i < s.len(); i++) begin
            rx_valid_o <= 1'b1;
            rx_char_o <= s[i];
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (!rx_ready_i && n < 2000);
            if (n >= 2000) stuck = 1'b1;
        end
        rx_valid_o <= 1'b0;
        rx_char_o <= ~s[s.len()-1];
    endtask
    // Takes response characters, stalling every other cycle when told to be slow.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (tx_valid_i && tx_ready_o) rxq.push_back(tx_char_i);
        tx_ready_o <= slow_i ? cyc[0] : 1'b1;
    end
endmodule
`default_nettype wire

//--- verification/common_command_status_sync_test.sv
`timescale 1ns/1ps
`default_nettype none
module common_command_status_sync_test;
    import cccs_pkg::*;
    logic clk_sys_i, srst_i, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, ops_busy_i, test_done_i;
    logic local_req_i, go_local_o, srq_o, reg_wr_i, reg_rd_i, slow;
    logic [7:0] rx_char_i, tx_char_o, test_code_i, stb_o, reg_wdata_i, reg_rdata_o, v, e;
    logic [1:0] reg_addr_i;
    cccs_act_t act_o;
    int mismatches, n_checks, seed, n_trg, n_pre, n_abt, n_tst, n_clr;
    cccs_core DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .rx_valid_i(rx_valid_i), .rx_char_i(rx_char_i),
        .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_char_o(tx_char_o), .tx_ready_i(tx_ready_i),
        .ops_busy_i(ops_busy_i), .test_done_i(test_done_i), .test_code_i(test_code_i),
        .local_req_i(local_req_i), .go_local_o(go_local_o), .act_o(act_o), .stb_o(stb_o), .srq_o(srq_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o));
    cccs_ctrl_model P (.clk_i(clk_sys_i), .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
        .rx_char_o(rx_char_i), .tx_valid_i(tx_valid_o), .tx_char_i(tx_char_o), .tx_ready_o(tx_ready_i),
        .slow_i(slow));
    // The clock toggles every half period of 12.5 ns.
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    // Counts the one-cycle action pulses.
    always @(posedge clk_sys_i) begin
        if (act_o.trigger) n_trg++;
        if (act_o.preset) n_pre++;
        if (act_o.abort) n_abt++;
        if (act_o.test_start) n_tst++;
        if (act_o.evt_clear) n_clr++;
    end
    // A stuck sender ends the run.
    always @(posedge clk_sys_i) begin
        if (P.stuck) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_sys_i);
        d = reg_rdata_o;
    endtask
    // Waits for a whole response line and compares it character by character.
    task automatic resp(input string exp);
        int n;
        n = 0;
        while (!(P.rxq.size() > 0 && P.rxq[$] == CH_NL) && n < 2000) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 2000) begin
            mismatches++;
            end_of_test();
        end else begin
            chk(8'(P.rxq.size()), 8'(exp.len()));
            for (int i = 0; i < exp.len() && i < P.rxq.size(); i++) chk(P.rxq[i], exp[i]);
            P.rxq.delete();
        end
    endtask
    initial begin
        {srst_i, ops_busy_i, test_done_i, local_req_i, reg_wr_i, reg_rd_i, slow} = 7'h7_f & 7'h4_0;
        {test_code_i, reg_wdata_i, reg_addr_i} = 18'h0_0000;
        {mismatches, n_checks, n_trg, n_pre, n_abt, n_tst, n_clr} = '0;
        seed = 32'h1c14_8c9c;
        tick(3);
        srst_i <= 1'b0;
        tick(2);
        chk(stb_o, 8'h00);
        chk(srq_o, 8'h00);
        rd(2'h1, v);
        chk(v, 8'h00);
        $display("test reset done");
        // Enable registers at both boundaries and random values, through a stalling sink.
        slow <= 1'b1;
        for (int k = 0; k < 10; k++) begin
            v = (k % 5 == 0) ? 8'h00 : (k % 5 == 1) ? 8'hFF : 8'($random(seed));
            e = (k < 5) ? v : v & 8'hBF;
            P.send($sformatf("*%s %0d;*%s?\n", k < 5 ? "ESE" : "SRE", v, k < 5 ? "ESE" : "SRE"));
            resp($sformatf("%0d\n", e));
        end
        slow <= 1'b0;
        $display("test enables done");
        P.send("*CLS;*ESE 1;*SRE 32\n");
        tick(4);
        ops_busy_i <= 1'b1;
        P.send("*OPC\n");
        tick(10);
        rd(2'h1, v);
        chk(v, 8'h00);
        ops_busy_i <= 1'b0;
        tick(5);
        rd(2'h1, v);
        chk(v, 8'h01);
        chk(stb_o & 8'h20, 8'h20);
        chk(srq_o, 8'h01);
        P.send("*STB?\n");
        resp("96\n");
        P.send("*ESR?\n");
        resp("1\n");
        rd(2'h1, v);
        chk(v, 8'h00);
        tick(3);
        chk(srq_o, 8'h00);
        $display("test opc done");
        wr(2'h2, 8'h80);
        tick(1);
        wr(2'h3, 8'h03);
        P.send("*CLS\n");
        tick(4);
        rd(2'h1, v);
        chk(v, 8'h00);
        chk(stb_o, 8'h00);
        chk(8'(n_clr), 8'h02);
        rd(2'h3, v);
        chk(v, 8'h00);
        rd(2'h2, v);
        chk(v, 8'h01);
        P.send("*SRE?\n");
        resp("32\n");
        P.send("*ABCD\n");
        tick(4);
        rd(2'h1, v);
        chk(v, 8'h20);
        P.send("*ESR?\n");
        resp("32\n");
        P.send("*AB;*ESR?\n");
        resp("32\n");
        P.send("*IDN?\n");
        resp("42\n");
        P.send("*OPT?\n");
        resp("0\n");
        $display("test clear done");
        ops_busy_i <= 1'b1;
        fork
            P.send("*OPC?\n");
            begin
                tick(20);
                chk(8'(P.rxq.size()), 8'h00);
                ops_busy_i <= 1'b0;
            end
        join
        resp("1\n");
        wr(2'h3, 8'h04);
        ops_busy_i <= 1'b1;
        fork
            P.send("*WAI;*IST?\n");
            begin
                tick(20);
                chk(rx_ready_o, 8'h00);
                chk(8'(P.rxq.size()), 8'h00);
                ops_busy_i <= 1'b0;
            end
        join
        resp("1\n");
        wr(2'h3, 8'h00);
        P.send("*IST?\n");
        resp("0\n");
        $display("test sync done");
        P.send("*TRG;*RST\n");
        tick(6);
        chk(8'(n_trg), 8'h01);
        chk(8'(n_pre), 8'h01);
        chk(8'(n_abt), 8'h00);
        ops_busy_i <= 1'b1;
        P.send("*TRG\n");
        tick(6);
        ops_busy_i <= 1'b0;
        chk(8'(n_trg), 8'h02);
        chk(8'(n_abt), 8'h01);
        $display("test actions done");
        v = 8'($random(seed));
        P.send("*TST?\n");
        local_req_i <= 1'b1;
        tick(10);
        chk(8'(n_tst), 8'h01);
        chk(go_local_o, 8'h00);
        test_done_i <= 1'b1;
        test_code_i <= v;
        tick(1);
        test_done_i <= 1'b0;
        resp($sformatf("%0d\n", v));
        tick(3);
        chk(go_local_o, 8'h01);
        $display("test selftest done");
        end_of_test();
    end
endmodule
`default_nettype wire
